// >>> bench/cfg_chain_chk.sv
// Port checker for the configuration chain block.
// Assumes one clock domain; bound into every instance of the block.
`timescale 1ns/1ps
module cfg_chain_chk #(
    parameter [15:0] RESTART_TO_CYC = 16'h0014
) (
    input wire clk_i,                    // System clock
    input wire rst_i,                    // Sync reset
    input wire wb_cyc_i,                 // Bus cycle
    input wire wb_stb_i,                 // Bus strobe
    input wire wb_ack_o,                 // Bus acknowledge
    input wire chain_enable_out_n_o,     // Chain enable out
    input wire config_serial_clock_o,    // Serial clock out
    input wire config_serial_clock_oe_o, // Serial clock drive
    input wire flash_select_n_o,         // Flash select
    input wire config_done_i,            // Done line
    input wire config_done_oe_o,         // Done pull-low
    input wire config_status_n_i,        // Status line
    input wire config_status_n_oe_o,     // Status pull-low
    input wire user_mode_o               // User operation
);
    reg [7:0] hi_cnt_r;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Cycles the done line has been high, saturating
    always @(posedge clk_i) begin
        if (rst_i || !config_done_i) begin
            hi_cnt_r <= 8'h00;
        end else if (hi_cnt_r != 8'hff) begin
            hi_cnt_r <= hi_cnt_r + 8'h01;
        end
    end
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    done_release_a: assert property (
        !chain_enable_out_n_o && $past(!chain_enable_out_n_o) |-> !config_done_oe_o)
        else $error("done held low after chain enable out");
    out_after_load_a: assert property (
        $fell(chain_enable_out_n_o) |-> $past(config_done_oe_o))
        else $error("chain enable out fell without a load");
    loading_holds_a: assert property (
        !flash_select_n_o && chain_enable_out_n_o |-> config_done_oe_o)
        else $error("done released while loading");
    slave_quiet_a: assert property (
        !config_serial_clock_oe_o |-> flash_select_n_o && !config_serial_clock_o)
        else $error("non-master drives flash");
    sclk_high_a: assert property (
        $rose(config_serial_clock_o) ##1 (config_status_n_i && !config_done_i) [*2]
        |-> config_serial_clock_o [*2] ##1 !config_serial_clock_o)
        else $error("serial clock high time wrong");
    abort_on_status_a: assert property (
        !config_status_n_i && !config_status_n_oe_o && !flash_select_n_o
        |-> ##[1:6] flash_select_n_o)
        else $error("load not aborted on status low");
    init_length_a: assert property (
        $rose(user_mode_o) |-> hi_cnt_r >= 8'h88 && hi_cnt_r <= 8'h92)
        else $error("init length wrong");
endmodule
bind cascaded_serial_config_chain cfg_chain_chk #(.RESTART_TO_CYC(RESTART_TO_CYC)) chk_u (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .chain_enable_out_n_o,
    .config_serial_clock_o, .config_serial_clock_oe_o, .flash_select_n_o, .config_done_i,
    .config_done_oe_o, .config_status_n_i, .config_status_n_oe_o, .user_mode_o);

// >>> bench/flash_model.sv
// Serial flash model: takes a read command, then streams framed image bits.
// Frames are 31 data bits plus even parity; bad_i spoils each parity bit.
`timescale 1ns/1ps
module flash_model (
    input wire sck_i,   // Serial clock from master
    input wire sel_n_i, // Select, active low
    input wire cmd_i,   // Command bit from master
    input wire bad_i,   // Spoil parity bits
    output reg dq_o     // Serial data to master
);
    reg [31:0] cmd_r;
    integer n_r;
    integer pos_r;
    initial begin
        cmd_r = 32'h00000000;
        n_r = 0;
        pos_r = 0;
        dq_o = 1'b0;
    end
    // Image bit p; the last of each frame is parity of the 31 before it
    function automatic logic bit_at(input integer p, input logic bad);
        logic x;
        x = bad;
        if (p % 32 != 31) return p[0] ^ p[2] ^ p[5];
        for (int k = p - 31; k < p; k++) x = x ^ k[0] ^ k[2] ^ k[5];
        return x;
    endfunction
    // Command latched on rising edges
    always @(posedge sck_i) begin
        if (!sel_n_i && n_r < 32) begin
            cmd_r <= {cmd_r[30:0], cmd_i};
            n_r <= n_r + 1;
        end
    end
    // Image bits launched on falling edges, in one continuous stream
    always @(negedge sck_i) begin
        if (!sel_n_i && n_r == 32) begin
            dq_o <= bit_at(pos_r, bad_i);
            pos_r <= pos_r + 1;
        end
    end
    // Deselect ends the read; released line shows the inverse level
    always @(posedge sel_n_i) begin
        n_r <= 0;
        pos_r <= 0;
        dq_o <= ~dq_o;
    end
endmodule

// >>> bench/tb.sv
// Testbench for the configuration chain block as master and as slave.
// Assumes the flash model in the master path; the bench plays the other devices.
`timescale 1ns/1ps
module tb;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, chain_enable_in_n_i, reconfig_request_n_i;
    logic config_serial_clock_i, sdat, corrupt, done_hold, stat_hold, fdq;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
    logic [3:0] wb_sel_i;
    logic [1:0] scheme_select_i;
    logic wb_ack_o, chain_enable_out_n_o, config_serial_clock_o, config_serial_clock_oe_o;
    logic flash_select_n_o, flash_command_input_o, config_done_o, config_done_oe_o;
    logic config_status_n_o, config_status_n_oe_o, user_mode_o;
    int fails, checks_done, cycles;
    // Shared open-drain lines with pull-ups; the bench pulls for other devices
    wire config_done_i = ~(config_done_oe_o | done_hold);
    wire config_status_n_i = ~(config_status_n_oe_o | stat_hold);
    wire config_serial_input_i = (scheme_select_i == 2'h0) ? fdq : sdat;
    cascaded_serial_config_chain #(.RESTART_TO_CYC(16'h0014)) uut (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .scheme_select_i, .chain_enable_in_n_i, .chain_enable_out_n_o,
        .reconfig_request_n_i, .config_serial_clock_i, .config_serial_clock_o,
        .config_serial_clock_oe_o, .config_serial_input_i, .flash_select_n_o,
        .flash_command_input_o, .config_done_i, .config_done_o, .config_done_oe_o,
        .config_status_n_i, .config_status_n_o, .config_status_n_oe_o, .user_mode_o);
    flash_model flash (.sck_i(config_serial_clock_o), .sel_n_i(flash_select_n_o),
        .cmd_i(flash_command_input_o), .bad_i(corrupt), .dq_o(fdq));
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Hang guard, well above the few thousand cycles each test needs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fails++;
            conclude();
        end
    end
    task conclude();
        if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One classic bus cycle; waits for ack, then idles one cycle
    task wb(input logic we, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Waits, bounded, for a chosen output to reach a level
    task wait_on(input int w, input logic v, output int n);
        logic s;
        n = 0;
        s = ~v;
        while (s !== v && n < 3000) begin
            @(posedge clk_i);
            n++;
            case (w)
                0: s = chain_enable_out_n_o;
                1: s = user_mode_o;
                2: s = config_status_n_oe_o;
                default: s = flash_select_n_o;
            endcase
        end
        if (n >= 3000) fails++;
    endtask
    task reset_to(input logic [1:0] sch);
        logic [31:0] q;
        rst_i <= 1'b1;
        scheme_select_i <= sch;
        corrupt <= 1'b0;
        done_hold <= 1'b0;
        stat_hold <= 1'b0;
        reconfig_request_n_i <= 1'b1;
        chain_enable_in_n_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b1, 32'h00000004, 32'h00000046, q);
    endtask
    // Serial bits to a slave at 80 ns; clock stands low between bits
    task sbits(input int n, input int off);
        for (int k = 0; k < n; k++) begin
            sdat <= (k < off) ? 1'b1 : flash.bit_at(k - off, 1'b0);
            repeat (5) @(posedge clk_i);
            config_serial_clock_i <= 1'b1;
            repeat (5) @(posedge clk_i);
            config_serial_clock_i <= 1'b0;
        end
    endtask
    task t_regs();
        logic [31:0] q;
        rst_i <= 1'b1;
        reset_to(2'h2);
        wb(1'b0, 32'h00000000, 32'h0, q);
        chk(q, 32'h00000001);
        wb(1'b0, 32'h00000008, 32'h0, q);
        chk(q, 32'h00000800);
        wb(1'b0, 32'h00000100, 32'h0, q);
        chk(q, 32'h00000000);
        chk(flash_select_n_o, 1'b1);
        chk({config_done_o, config_status_n_o}, 2'h0);
        wb(1'b1, 32'h00000000, 32'h00000009, q);
        wb(1'b0, 32'h00000000, 32'h0, q);
        chk(q, 32'h00000001);
        wb(1'b0, 32'h0000000c, 32'h0, q);
        chk(q, 32'h00000067);
    endtask
    task t_master(input logic comp);
        logic [31:0] q;
        int n;
        reset_to(2'h0);
        wb(1'b1, 32'h00000008, 32'h00000028, q);
        wb(1'b1, 32'h00000000, {30'h0, comp, 1'b1}, q);
        done_hold <= 1'b1;
        wait_on(0, 1'b0, n);
        chk(flash.cmd_r, 32'h03000000);
        wb(1'b0, 32'h00000010, 32'h0, q);
        chk(q, comp ? 32'h00000028 : 32'h00000046);
        chk(config_done_oe_o, 1'b0);
        repeat (30) @(posedge clk_i);
        chk(flash_select_n_o, 1'b0);
        chk(user_mode_o, 1'b0);
        done_hold <= 1'b0;
        wait_on(1, 1'b1, n);
        chk(n >= 136 && n <= 146, 1'b1);
    endtask
    task t_error();
        logic [31:0] q;
        int n;
        reset_to(2'h0);
        corrupt <= 1'b1;
        wait_on(2, 1'b0, n);
        wait_on(2, 1'b1, n);
        wait_on(2, 1'b0, n);
        chk(n >= 20 && n <= 22, 1'b1);
        wait_on(3, 1'b0, n);
        chk(n < 20, 1'b1);
        wb(1'b1, 32'h00000000, 32'h00000000, q);
        wait_on(2, 1'b1, n);
        repeat (60) @(posedge clk_i);
        chk(config_status_n_oe_o, 1'b1);
        reconfig_request_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        reconfig_request_n_i <= 1'b1;
        corrupt <= 1'b0;
        wait_on(0, 1'b0, n);
        chk(chain_enable_out_n_o, 1'b0);
    endtask
    task t_abort();
        int n;
        reset_to(2'h0);
        wait_on(3, 1'b0, n);
        repeat (100) @(posedge clk_i);
        stat_hold <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(flash_select_n_o, 1'b1);
        chk(config_status_n_oe_o, 1'b0);
        stat_hold <= 1'b0;
        wait_on(0, 1'b0, n);
        chk(chain_enable_out_n_o, 1'b0);
    endtask
    task t_slave(input logic skip);
        logic [31:0] q;
        int n;
        reset_to(2'h1);
        wb(1'b1, 32'h00000000, {29'h0, skip, 2'h1}, q);
        chain_enable_in_n_i <= !skip;
        repeat (20) @(posedge clk_i);
        sbits(8, 0);
        wb(1'b0, 32'h00000010, 32'h0, q);
        chk(q, 32'h00000000);
        chain_enable_in_n_i <= 1'b0;
        sbits(skip ? 94 : 70, skip ? 24 : 0);
        repeat (6) @(posedge clk_i);
        chk(chain_enable_out_n_o, 1'b0);
        wb(1'b0, 32'h00000010, 32'h0, q);
        chk(q, 32'h00000046);
        wait_on(1, 1'b1, n);
        chk(user_mode_o, 1'b1);
    endtask
    initial begin
        {fails, checks_done, cycles} = '0;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, config_serial_clock_i, sdat} = '0;
        {corrupt, done_hold, stat_hold, chain_enable_in_n_i} = '0;
        reconfig_request_n_i = 1'b1;
        {wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hf;
        scheme_select_i = 2'h0;
        @(posedge clk_i);
        t_regs();
        t_master(1'b0);
        t_master(1'b1);
        t_error();
        t_abort();
        t_slave(1'b0);
        t_slave(1'b1);
        conclude();
    end
endmodule

// >>> core/cascaded_serial_config_chain.v
// Configuration chain logic of one device: master or passive slave.
// Assumes shared open-drain done and status lines with outside pull-ups,
// and a serial flash that answers a read command with the image stream.
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "cfg_chain_defines.vh"
module cascaded_serial_config_chain #(
    parameter [15:0] RESTART_TO_CYC = `RESTART_TO_CYC
) (
    input wire clk_i,                   // 125 MHz clock
    input wire rst_i,                   // Sync reset, high
    input wire wb_cyc_i,                // Wishbone cycle
    input wire wb_stb_i,                // Wishbone strobe
    input wire wb_we_i,                 // Wishbone write
    input wire [31:0] wb_adr_i,         // Byte address
    input wire [3:0] wb_sel_i,          // Byte enables
    input wire [31:0] wb_dat_i,         // Write data
    output reg [31:0] wb_dat_o,         // Read data
    output reg wb_ack_o,                // Acknowledge
    input wire [1:0] scheme_select_i,   // Scheme strap
    input wire chain_enable_in_n_i,     // Chain enable in
    output reg chain_enable_out_n_o,    // Chain enable out
    input wire reconfig_request_n_i,    // Reconfig request
    input wire config_serial_clock_i,   // Serial clock in
    output reg config_serial_clock_o,   // Serial clock out
    output reg config_serial_clock_oe_o, // Clock drive enable
    input wire config_serial_input_i,   // Serial data in
    output reg flash_select_n_o,        // Flash select
    output reg flash_command_input_o,   // Flash command data
    input wire config_done_i,           // Done line level
    output reg config_done_o,           // Done drive value
    output reg config_done_oe_o,        // Done pull-low enable
    input wire config_status_n_i,       // Status line level
    output reg config_status_n_o,       // Status drive value
    output reg config_status_n_oe_o,    // Status pull-low enable
    output reg user_mode_o              // In user operation
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_CMD = 3'h1;
    localparam [2:0] ST_LOAD = 3'h2;
    localparam [2:0] ST_PASS = 3'h3;
    localparam [2:0] ST_INIT = 3'h4;
    localparam [2:0] ST_USER = 3'h5;
    localparam [2:0] ST_ERR = 3'h6;
    localparam [2:0] ST_OFF = 3'h7;

    // Byte-lane merge for register writes
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] sel;
        integer i;
        begin
            merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    wire sclk_s;
    wire sclk_rise;
    wire data_s;
    wire ce_s;
    wire rcfg_s;
    wire done_s;
    wire stat_s;
    wire sel0_s;
    wire sel1_s;

    // Every pin passes two flops before use
    pin_sync u_sclk (
        .clk_i(clk_i), .rst_i(rst_i), .pin_i(config_serial_clock_i),
        .q_o(sclk_s), .rise_o(sclk_rise), .fall_o()
    );
    pin_sync u_data (
        .clk_i(clk_i), .rst_i(rst_i), .pin_i(config_serial_input_i),
        .q_o(data_s), .rise_o(), .fall_o()
    );
    pin_sync u_ce (
        .clk_i(clk_i), .rst_i(rst_i), .pin_i(chain_enable_in_n_i),
        .q_o(ce_s), .rise_o(), .fall_o()
    );
    pin_sync u_rcfg (
        .clk_i(clk_i), .rst_i(rst_i), .pin_i(reconfig_request_n_i),
        .q_o(rcfg_s), .rise_o(), .fall_o()
    );
    pin_sync u_done (
        .clk_i(clk_i), .rst_i(rst_i), .pin_i(config_done_i),
        .q_o(done_s), .rise_o(), .fall_o()
    );
    pin_sync u_stat (
        .clk_i(clk_i), .rst_i(rst_i), .pin_i(config_status_n_i),
        .q_o(stat_s), .rise_o(), .fall_o()
    );
    pin_sync u_sel0 (
        .clk_i(clk_i), .rst_i(rst_i), .pin_i(scheme_select_i[0]),
        .q_o(sel0_s), .rise_o(), .fall_o()
    );
    pin_sync u_sel1 (
        .clk_i(clk_i), .rst_i(rst_i), .pin_i(scheme_select_i[1]),
        .q_o(sel1_s), .rise_o(), .fall_o()
    );

    reg [2:0] state_r;
    reg [1:0] strap_cnt_r;
    reg strap_ok_r;
    reg is_master_r;
    reg is_slave_r;
    reg [2:0] ctrl_r;
    reg [31:0] len_r;
    reg [31:0] clen_r;
    reg soft_recfg_r;
    reg [31:0] bit_cnt_r;
    reg [5:0] cmd_cnt_r;
    reg [31:0] cmd_sr_r;
    reg [4:0] frame_cnt_r;
    reg par_r;
    reg own_err_r;
    reg [15:0] timer_r;
    reg [7:0] init_cnt_r;
    reg [2:0] hcnt_r;

    // Strap caught a few cycles after reset, once the synchroniser settled
    always @(posedge clk_i) begin
        if (rst_i) begin
            strap_cnt_r <= 2'h0;
            strap_ok_r <= 1'b0;
            is_master_r <= 1'b0;
            is_slave_r <= 1'b0;
        end else if (!strap_ok_r) begin
            if (strap_cnt_r == `STRAP_WAIT) begin
                strap_ok_r <= 1'b1;
                is_master_r <= ({sel1_s, sel0_s} == `SCHEME_ACTIVE);
                is_slave_r <= ({sel1_s, sel0_s} == `SCHEME_PASSIVE);
            end else begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
            end
        end
    end

    wire loading = (state_r == ST_CMD) || (state_r == ST_LOAD);
    wire clk_run = is_master_r && (loading || (state_r == ST_PASS));
    wire half_end = ({29'h0, hcnt_r} == (`SCLK_HALF_CYC - 1));
    wire m_fall = clk_run && half_end && config_serial_clock_o;
    // Slave counts clock edges only while enabled
    wire s_tick = is_slave_r && sclk_rise && !ce_s;
    wire tick = is_master_r ? m_fall : s_tick;
    wire recfg_req = !rcfg_s || soft_recfg_r;
    wire [31:0] end_len = ctrl_r[`CTRL_COMP] ? clen_r : len_r;
    wire last_bit = (bit_cnt_r == (end_len - 32'h1));
    wire frame_end = (frame_cnt_r == `FRAME_LAST);

    // Serial clock divider; half period keeps the rate at 14 MHz or more
    always @(posedge clk_i) begin
        if (rst_i || !clk_run) begin
            hcnt_r <= 3'h0;
            config_serial_clock_o <= 1'b0;
        end else if (half_end) begin
            hcnt_r <= 3'h0;
            config_serial_clock_o <= ~config_serial_clock_o;
        end else begin
            hcnt_r <= hcnt_r + 3'h1;
        end
    end

    // Main sequence; a bus or pin reconfig request overrides every state
    always @(posedge clk_i) begin
        if (rst_i || recfg_req) begin
            state_r <= ST_IDLE;
            own_err_r <= 1'b0;
            bit_cnt_r <= 32'h0;
            cmd_cnt_r <= 6'h0;
            cmd_sr_r <= `READ_WORD;
            frame_cnt_r <= 5'h0;
            par_r <= 1'b0;
            timer_r <= 16'h0;
            init_cnt_r <= 8'h0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    bit_cnt_r <= 32'h0;
                    cmd_cnt_r <= 6'h0;
                    cmd_sr_r <= `READ_WORD;
                    frame_cnt_r <= 5'h0;
                    par_r <= 1'b0;
                    timer_r <= 16'h0;
                    init_cnt_r <= 8'h0;
                    // Start together once status is released
                    if (strap_ok_r && stat_s) begin
                        if (!is_master_r && !is_slave_r) begin
                            state_r <= ST_OFF;
                        end else if (is_master_r || ctrl_r[`CTRL_SKIP]) begin
                            state_r <= ST_CMD;
                        end else begin
                            state_r <= ST_LOAD;
                        end
                    end
                end
                ST_CMD: begin
                    // Master shifts the read command; slave skips its clocks
                    if (!stat_s) begin
                        state_r <= ST_IDLE;
                    end else if (tick) begin
                        cmd_sr_r <= {cmd_sr_r[30:0], 1'b1};
                        cmd_cnt_r <= cmd_cnt_r + 6'h1;
                        if (cmd_cnt_r == `CMD_LAST) begin
                            state_r <= ST_LOAD;
                        end
                    end
                end
                ST_LOAD: begin
                    if (!stat_s) begin
                        state_r <= ST_IDLE;
                    end else if (tick) begin
                        // Bits count toward this device's share of the stream
                        bit_cnt_r <= bit_cnt_r + 32'h1;
                        frame_cnt_r <= frame_cnt_r + 5'h1;
                        if (frame_end) begin
                            par_r <= 1'b0;
                        end else begin
                            par_r <= par_r ^ data_s;
                        end
                        if (frame_end && (par_r != data_s)) begin
                            state_r <= ST_ERR;
                            own_err_r <= 1'b1;
                        end else if (last_bit) begin
                            state_r <= ST_PASS;
                        end
                    end
                end
                ST_PASS: begin
                    // Master keeps clocking the next image to the slaves
                    if (!stat_s) begin
                        state_r <= ST_IDLE;
                    end else if (done_s) begin
                        state_r <= ST_INIT;
                    end
                end
                ST_INIT: begin
                    init_cnt_r <= init_cnt_r + 8'h1;
                    if (init_cnt_r == `INIT_LAST) begin
                        state_r <= ST_USER;
                    end
                end
                ST_USER: begin
                    state_r <= ST_USER;
                end
                ST_ERR: begin
                    // Without auto restart, wait here for a reconfig pulse
                    if (timer_r != RESTART_TO_CYC - 16'h1) begin
                        timer_r <= timer_r + 16'h1;
                    end else if (ctrl_r[`CTRL_AUTO]) begin
                        own_err_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                ST_OFF: begin
                    state_r <= ST_OFF;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Pin drivers, all registered
    always @(posedge clk_i) begin
        if (rst_i) begin
            chain_enable_out_n_o <= 1'b1;
            config_serial_clock_oe_o <= 1'b0;
            flash_select_n_o <= 1'b1;
            flash_command_input_o <= 1'b1;
            config_done_o <= 1'b0;
            config_done_oe_o <= 1'b1;
            config_status_n_o <= 1'b0;
            config_status_n_oe_o <= 1'b1;
            user_mode_o <= 1'b0;
        end else begin
            // High while loading own image, low once it is complete
            chain_enable_out_n_o <= !((state_r == ST_PASS) ||
                (state_r == ST_INIT) || (state_r == ST_USER));
            config_serial_clock_oe_o <= is_master_r;
            flash_select_n_o <= !clk_run;
            flash_command_input_o <= (is_master_r && (state_r == ST_CMD)) ?
                cmd_sr_r[31] : 1'b1;
            config_done_o <= 1'b0;
            // Released at the same time chain enable out drops
            config_done_oe_o <= (state_r == ST_IDLE) || loading ||
                (state_r == ST_ERR);
            config_status_n_o <= 1'b0;
            config_status_n_oe_o <= (state_r == ST_ERR) || !rcfg_s ||
                !strap_ok_r;
            user_mode_o <= (state_r == ST_USER);
        end
    end

    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr = bus_req && wb_we_i;
    wire hit_hi = (wb_adr_i[31:8] == 24'h0);
    wire [7:0] offs = wb_adr_i[7:0];
    wire [31:0] ctrl_word = {29'h0, ctrl_r};
    wire [31:0] ctrl_new = merge(ctrl_word, wb_dat_i, wb_sel_i);

    // Register writes; reconfig bit is a self-clearing pulse
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `CTRL_RST;
            len_r <= `LEN_RST;
            clen_r <= `CLEN_RST;
            soft_recfg_r <= 1'b0;
        end else begin
            soft_recfg_r <= 1'b0;
            if (bus_wr && hit_hi) begin
                if (offs == `REG_CTRL) begin
                    ctrl_r <= ctrl_new[2:0];
                    soft_recfg_r <= ctrl_new[`CTRL_RECFG];
                end
                if (offs == `REG_LEN) begin
                    len_r <= merge(len_r, wb_dat_i, wb_sel_i);
                end
                if (offs == `REG_CLEN) begin
                    clen_r <= merge(clen_r, wb_dat_i, wb_sel_i);
                end
            end
        end
    end

    // One-wait-state answer; unmapped reads give zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req) begin
                wb_dat_o <= 32'h0;
                if (hit_hi && (offs == `REG_CTRL)) begin
                    wb_dat_o <= ctrl_word;
                end
                if (hit_hi && (offs == `REG_LEN)) begin
                    wb_dat_o <= len_r;
                end
                if (hit_hi && (offs == `REG_CLEN)) begin
                    wb_dat_o <= clen_r;
                end
                if (hit_hi && (offs == `REG_STAT)) begin
                    wb_dat_o <= {23'h0, sclk_s, user_mode_o, stat_s, done_s,
                        own_err_r, is_master_r, state_r};
                end
                if (hit_hi && (offs == `REG_CNT)) begin
                    wb_dat_o <= bit_cnt_r;
                end
            end
        end
    end
endmodule

// >>> core/cfg_chain_defines.vh
// Constants for the cascaded serial configuration chain.
// Assumes a 125 MHz system clock and a classic Wishbone register bus.
`ifndef CFG_CHAIN_DEFINES_VH
`define CFG_CHAIN_DEFINES_VH

// Timing
`define CLK_PERIOD_NS 8
`define SCLK_MAX_PERIOD_NS 71
`define SCLK_HALF_CYC ((`SCLK_MAX_PERIOD_NS / `CLK_PERIOD_NS) / 2)
`define RESTART_TO_US 40
`define RESTART_TO_CYC ((`RESTART_TO_US * 1000) / `CLK_PERIOD_NS)
`define INIT_LAST 8'h87
`define STRAP_WAIT 2'h3

// Flash read command and 24-bit start address, sent msb first
`define READ_WORD 32'h03000000
`define CMD_LAST 6'h1f
// Frame of 31 data bits and one even parity bit
`define FRAME_LAST 5'h1f

// Scheme select codes
`define SCHEME_ACTIVE 2'h0
`define SCHEME_PASSIVE 2'h1

// Register byte offsets (low address byte)
`define REG_CTRL 8'h00
`define REG_LEN 8'h04
`define REG_CLEN 8'h08
`define REG_STAT 8'h0c
`define REG_CNT 8'h10

// Control bits
`define CTRL_AUTO 0
`define CTRL_COMP 1
`define CTRL_SKIP 2
`define CTRL_RECFG 3

// Reset values
`define CTRL_RST 3'h1
`define LEN_RST 32'h00001000
`define CLEN_RST 32'h00000800

`endif

// >>> core/pin_sync.v
// Two-flop synchroniser for one pin with rise and fall detection.
// Assumes the pin is asynchronous to clk_i; edges are taken past flop two.
`timescale 1ns/1ps
module pin_sync (
    input wire clk_i,  // System clock
    input wire rst_i,  // Synchronous reset
    input wire pin_i,  // Asynchronous pin
    output reg q_o,    // Synchronised level
    output wire rise_o, // One-cycle pulse on rise
    output wire fall_o  // One-cycle pulse on fall
);
    reg meta_r;
    reg last_r;

    // Only the second flop reads the first
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b1;
            q_o <= 1'b1;
            last_r <= 1'b1;
        end else begin
            meta_r <= pin_i;
            q_o <= meta_r;
            last_r <= q_o;
        end
    end

    // Edges from the settled stages
    assign rise_o = q_o & ~last_r;
    assign fall_o = ~q_o & last_r;
endmodule
